//--- hdl/pbcpf_pkg.sv
// Purpose: Shared constants and types for the port B/C pin function block
// Assumes: AHB-Lite slave, 32-bit data, registers in the low 16 bits
// Notes: Register offsets are byte addresses within the slave window
package pbcpf_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned PB_PINS = 7;
  localparam int unsigned PC_PINS = 16;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned IRQ_N = 5;
  localparam int unsigned POE_N = 4;
  localparam int unsigned IDX_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_PB_SEL = 8'h00;
  localparam logic [7:0] OFS_PC_DIR = 8'h04;
  localparam logic [7:0] OFS_PC_SEL = 8'h08;

  localparam logic [15:0] REG_RST = 16'h0000;
  // Writable port B bits: 13:4, 2 and 0
  localparam logic [15:0] PB_SEL_MASK = 16'h3FF5;

  // Port B field positions
  localparam int unsigned PB0_BIT = 0;
  localparam int unsigned PB1_BIT = 2;
  localparam int unsigned PB2_LSB = 4;
  localparam int unsigned PB_FLD_W = 2;
  localparam int unsigned PB_FLD_BASE_PIN = 2;
  localparam int unsigned PB_FLD_N = 5;
  localparam int unsigned PB_READ_WRITE_STROBE_FLD = 3;
  localparam int unsigned PB_A18_FLD = 4;
  localparam int unsigned ABIT_PB0 = 16;
  localparam int unsigned ABIT_PB1 = 17;
  localparam int unsigned ABIT_PB6 = 18;

  typedef enum logic [1:0] {
    FLD_GPIO = 2'b00,
    FLD_IRQ = 2'b01,
    FLD_ALT = 2'b10,
    FLD_STROBE = 2'b11
  } pbcpf_fld_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } pbcpf_bus_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Core-side strobes, ordered by port B field index
  typedef struct packed {
    logic bus_grant_ack;
    logic read_write_strobe;
    logic upper_column_strobe;
    logic lower_column_strobe;
    logic row_strobe;
  } pbcpf_strobe_t;

  typedef struct packed {
    logic [PB_PINS-1:0] pb_out;
    logic [PB_PINS-1:0] pb_oe_n;
    logic [PC_PINS-1:0] pc_out;
    logic [PC_PINS-1:0] pc_oe_n;
  } pbcpf_pin_t;

  typedef struct packed {
    pbcpf_bus_t bus;
    logic wr;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] pb_sel;
    logic [REG_W-1:0] pc_dir;
    logic [REG_W-1:0] pc_sel;
    pbcpf_pin_t pins;
    logic [IRQ_N-1:0] irq;
    logic [POE_N-1:0] poe;
  } pbcpf_state_t;

  localparam pbcpf_state_t STATE_RST = '{
    bus: BUS_IDLE, wr: 1'h0, idx: 8'h00,
    pb_sel: REG_RST, pc_dir: REG_RST, pc_sel: REG_RST,
    pins: '{pb_out: 7'h00, pb_oe_n: 7'h7F, pc_out: 16'h0000, pc_oe_n: 16'hFFFF},
    irq: 5'h1F, poe: 4'hF};

endpackage

//--- hdl/pbcpf_pin_cell.sv
// Purpose: One pin shared between general I/O and an address output
// Assumes: Mode inputs are mutually exclusive levels
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module pbcpf_pin_cell (
  // Selection and mode
  input wire logic sel,
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  // General I/O side
  input wire logic dir,
  input wire logic gpio_out,
  // Address side
  input wire logic addr_bit,
  // Pin drive
  output logic pin_out,
  output logic pin_oe_n
);

  logic gpio;

  always_comb
  begin
    gpio = sel ? single_chip_mode : !rom_invalid_mode;
    pin_out = gpio ? gpio_out : addr_bit;
    pin_oe_n = gpio ? !dir : 1'h0;
  end

endmodule

//--- hdl/pbcpf_top.sv
// Purpose: Port B (pins 6..0) and port C pin function and direction control
// Assumes: hresetn is the external power-on reset; other resets do not reach here
// Notes: Register changes reach the pins one clock after the write data phase
// Contract
// - Port B pin 6 field picks I/O, interrupt four, address 18 or grant ack; last two are I/O in single-chip mode.
// - Port B pin 5 field picks I/O, interrupt three, disable request three or read/write strobe.
// - Port B pin 4 field picks I/O, interrupt two, disable request two or upper column strobe, strobe is I/O in single-chip mode.
// - Port B pin 3 field picks I/O, interrupt one, disable request one or lower column strobe, strobe is I/O in single-chip mode.
// - Port B pin 2 field picks I/O, interrupt zero, disable request zero or row strobe, strobe is I/O in single-chip mode.
// - Port B select bits 3 and 1 always read zero and software writes them as zero.
// - Port B bit 2 gives I/O or address 17, with address 17 when ROM is invalid and I/O in single-chip mode.
// - Port B bit 0 gives I/O or address 16, with address 16 when ROM is invalid and I/O in single-chip mode.
// - The port C direction register holds one bit per pin, 1 for output and 0 for input.
// - A port C direction bit only acts while its pin is general I/O.
// - The port C direction register clears only on power-on reset and holds through all else.
// - The port C select register holds 16 read/write bits that the mode may override.
// - The port C select register clears only on power-on reset and holds through all else.
// - Port C select bit n gives I/O or address n, with address n when ROM is invalid and I/O in single-chip mode.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module pbcpf_top (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Operating mode
  input wire logic single_chip_mode,
  input wire logic rom_invalid_mode,
  // Core side sources
  input wire logic [pbcpf_pkg::ADDR_W-1:0] address_bus,
  input wire pbcpf_pkg::pbcpf_strobe_t strobes,
  input wire logic [pbcpf_pkg::PB_PINS-1:0] portb_gpio_out,
  input wire logic [pbcpf_pkg::PB_PINS-1:0] portb_gpio_dir,
  input wire logic [pbcpf_pkg::PC_PINS-1:0] portc_gpio_out,
  // Pins
  input wire logic [pbcpf_pkg::PB_PINS-1:0] portb_pin_in,
  output pbcpf_pkg::pbcpf_pin_t pins,
  // Routed pin inputs, idle high when not selected
  output logic [pbcpf_pkg::IRQ_N-1:0] interrupt_lines,
  output logic [pbcpf_pkg::POE_N-1:0] output_disable_requests
);

  pbcpf_pkg::pbcpf_state_t st_ff;
  pbcpf_pkg::pbcpf_state_t nxt_st;
  logic [pbcpf_pkg::PC_PINS-1:0] pc_out;
  logic [pbcpf_pkg::PC_PINS-1:0] pc_oe_n;
  logic [1:0] pbl_out;
  logic [1:0] pbl_oe_n;
  logic [1:0] pbl_sel;
  logic [1:0] pbl_addr;
  logic [pbcpf_pkg::PB_FLD_N-1:0][1:0] fld;
  logic [pbcpf_pkg::REG_W-1:0] rd_val;

  assign pbl_sel = {st_ff.pb_sel[pbcpf_pkg::PB1_BIT], st_ff.pb_sel[pbcpf_pkg::PB0_BIT]};
  assign pbl_addr = {address_bus[pbcpf_pkg::ABIT_PB1], address_bus[pbcpf_pkg::ABIT_PB0]};

  // Port C pins, one cell each
  for (genvar n = 0; n < pbcpf_pkg::PC_PINS; n++)
  begin : g_pc
    pbcpf_pin_cell u_cell (
      .sel(st_ff.pc_sel[n]),
      .single_chip_mode(single_chip_mode),
      .rom_invalid_mode(rom_invalid_mode),
      .dir(st_ff.pc_dir[n]),
      .gpio_out(portc_gpio_out[n]),
      .addr_bit(address_bus[n]),
      .pin_out(pc_out[n]),
      .pin_oe_n(pc_oe_n[n])
    );
  end

  // Port B pins 1 and 0 behave like port C pins
  for (genvar n = 0; n < 2; n++)
  begin : g_pbl
    pbcpf_pin_cell u_cell (
      .sel(pbl_sel[n]),
      .single_chip_mode(single_chip_mode),
      .rom_invalid_mode(rom_invalid_mode),
      .dir(portb_gpio_dir[n]),
      .gpio_out(portb_gpio_out[n]),
      .addr_bit(pbl_addr[n]),
      .pin_out(pbl_out[n]),
      .pin_oe_n(pbl_oe_n[n])
    );
  end

  always_comb
  begin
    logic [pbcpf_pkg::PB_FLD_N-1:0] alt_out;
    logic fallback;
    int unsigned p;
    alt_out = strobes;
    fallback = 1'h0;
    p = 0;
    nxt_st = st_ff;
    // Write data phase
    if (st_ff.bus == pbcpf_pkg::BUS_DATA && st_ff.wr)
    begin
      case (st_ff.idx)
        pbcpf_pkg::OFS_PB_SEL: nxt_st.pb_sel = hwdata[15:0] & pbcpf_pkg::PB_SEL_MASK;
        pbcpf_pkg::OFS_PC_DIR: nxt_st.pc_dir = hwdata[15:0];
        pbcpf_pkg::OFS_PC_SEL: nxt_st.pc_sel = hwdata[15:0];
        default: nxt_st.pc_sel = st_ff.pc_sel;
      endcase
    end
    // Address phase
    if (hsel && hready && htrans == pbcpf_pkg::HTRANS_NONSEQ)
    begin
      nxt_st.bus = pbcpf_pkg::BUS_DATA;
      nxt_st.wr = hwrite;
      nxt_st.idx = haddr[pbcpf_pkg::IDX_W-1:0];
    end
    else
    begin
      nxt_st.bus = pbcpf_pkg::BUS_IDLE;
      nxt_st.wr = 1'h0;
    end
    // Port C and port B low pins
    nxt_st.pins.pc_out = pc_out;
    nxt_st.pins.pc_oe_n = pc_oe_n;
    nxt_st.pins.pb_out[1:0] = pbl_out;
    nxt_st.pins.pb_oe_n[1:0] = pbl_oe_n;
    nxt_st.irq = '1;
    nxt_st.poe = '1;
    // Port B pins 6..2, two-bit fields
    for (int k = 0; k < pbcpf_pkg::PB_FLD_N; k++)
    begin
      p = pbcpf_pkg::PB_FLD_BASE_PIN + k;
      fallback = single_chip_mode && ((fld[k] == pbcpf_pkg::FLD_STROBE
        && k != pbcpf_pkg::PB_READ_WRITE_STROBE_FLD) || (fld[k] == pbcpf_pkg::FLD_ALT
        && k == pbcpf_pkg::PB_A18_FLD));
      nxt_st.pins.pb_out[p] = portb_gpio_out[p];
      nxt_st.pins.pb_oe_n[p] = !portb_gpio_dir[p];
      if (!fallback)
      begin
        case (fld[k])
          pbcpf_pkg::FLD_IRQ:
          begin
            nxt_st.pins.pb_oe_n[p] = 1'h1;
            nxt_st.irq[k] = portb_pin_in[p];
          end
          pbcpf_pkg::FLD_ALT:
          begin
            if (k == pbcpf_pkg::PB_A18_FLD)
            begin
              nxt_st.pins.pb_out[p] = address_bus[pbcpf_pkg::ABIT_PB6];
              nxt_st.pins.pb_oe_n[p] = 1'h0;
            end
            else
            begin
              nxt_st.pins.pb_oe_n[p] = 1'h1;
              nxt_st.poe[k] = portb_pin_in[p];
            end
          end
          pbcpf_pkg::FLD_STROBE:
          begin
            nxt_st.pins.pb_out[p] = alt_out[k];
            nxt_st.pins.pb_oe_n[p] = 1'h0;
          end
          default: nxt_st.pins.pb_out[p] = portb_gpio_out[p];
        endcase
      end
    end
  end

  always_comb
  begin
    for (int k = 0; k < pbcpf_pkg::PB_FLD_N; k++)
    begin
      fld[k] = st_ff.pb_sel[pbcpf_pkg::PB2_LSB + pbcpf_pkg::PB_FLD_W * k +: 2];
    end
  end

  // Read data from stored settings, never pin levels
  always_comb
  begin
    rd_val = pbcpf_pkg::REG_RST;
    if (st_ff.bus == pbcpf_pkg::BUS_DATA && !st_ff.wr)
    begin
      case (st_ff.idx)
        pbcpf_pkg::OFS_PB_SEL: rd_val = st_ff.pb_sel & pbcpf_pkg::PB_SEL_MASK;
        pbcpf_pkg::OFS_PC_DIR: rd_val = st_ff.pc_dir;
        pbcpf_pkg::OFS_PC_SEL: rd_val = st_ff.pc_sel;
        default: rd_val = pbcpf_pkg::REG_RST;
      endcase
    end
  end

  // Only hresetn clears the registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= pbcpf_pkg::STATE_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = {16'h0000, rd_val};
  assign hreadyout = 1'h1;
  assign hresp = pbcpf_pkg::HRESP_OKAY;
  assign pins = st_ff.pins;
  assign interrupt_lines = st_ff.irq;
  assign output_disable_requests = st_ff.poe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_dp;
  assign wr_dp = st_ff.bus == pbcpf_pkg::BUS_DATA && st_ff.wr;

  chk_pb6_grant: assert property (fld[4] == 2'h3 && !single_chip_mode
    |=> !pins.pb_oe_n[6] && pins.pb_out[6] == $past(strobes.bus_grant_ack))
    else $error("pin 6 grant ack not driven");
  chk_pb6_single: assert property (fld[4][1] && single_chip_mode
    |=> pins.pb_oe_n[6] == !$past(portb_gpio_dir[6]))
    else $error("pin 6 not general I/O in single-chip mode");
  chk_pb5_read_write_strobe: assert property (fld[3] == 2'h3
    |=> !pins.pb_oe_n[5] && pins.pb_out[5] == $past(strobes.read_write_strobe))
    else $error("pin 5 read/write strobe not driven");
  chk_pb4_single: assert property (fld[2] == 2'h3 && single_chip_mode
    |=> pins.pb_out[4] == $past(portb_gpio_out[4]))
    else $error("pin 4 strobe not reverted");
  chk_pb3_irq: assert property (fld[1] == 2'h1
    |=> pins.pb_oe_n[3] && interrupt_lines[1] == $past(portb_pin_in[3]))
    else $error("pin 3 interrupt not routed");
  chk_pb2_poe: assert property (fld[0] == 2'h2
    |=> pins.pb_oe_n[2] && output_disable_requests[0] == $past(portb_pin_in[2]))
    else $error("pin 2 disable request not routed");
  chk_rsv_zero: assert property (st_ff.bus == pbcpf_pkg::BUS_DATA && !st_ff.wr
    && st_ff.idx == pbcpf_pkg::OFS_PB_SEL
    |-> hrdata[3] == 1'h0 && hrdata[1] == 1'h0)
    else $error("reserved bit reads non-zero");
  chk_pb1_rom: assert property (!st_ff.pb_sel[2] && rom_invalid_mode
    |=> !pins.pb_oe_n[1] && pins.pb_out[1] == $past(address_bus[17]))
    else $error("pin 1 address 17 missing");
  chk_pb0_addr: assert property (st_ff.pb_sel[0] && !single_chip_mode
    |=> !pins.pb_oe_n[0] && pins.pb_out[0] == $past(address_bus[16]))
    else $error("pin 0 address 16 missing");
  chk_pc_dir: assert property (!st_ff.pc_sel[3] && !rom_invalid_mode
    |=> pins.pc_oe_n[3] == !$past(st_ff.pc_dir[3]))
    else $error("port C direction not applied");
  chk_pc_alt: assert property (st_ff.pc_sel[15] && !single_chip_mode
    |=> !pins.pc_oe_n[15] && pins.pc_out[15] == $past(address_bus[15]))
    else $error("port C address output wrong");
  chk_regs_hold: assert property (!wr_dp
    |=> $stable(st_ff.pc_dir) && $stable(st_ff.pc_sel) && $stable(st_ff.pb_sel))
    else $error("register changed without a write");
  chk_pcsel_write: assert property (wr_dp && st_ff.idx == pbcpf_pkg::OFS_PC_SEL
    |=> st_ff.pc_sel == $past(hwdata[15:0]))
    else $error("port C select write lost");
  chk_pc_single: assert property (st_ff.pc_sel[7] && single_chip_mode
    |=> pins.pc_out[7] == $past(portc_gpio_out[7]))
    else $error("port C pin not I/O in single-chip mode");
  chk_read_back: assert property (wr_dp && st_ff.idx == pbcpf_pkg::OFS_PC_DIR
    ##1 !wr_dp
    ##1 st_ff.bus == pbcpf_pkg::BUS_DATA && !st_ff.wr && st_ff.idx == pbcpf_pkg::OFS_PC_DIR
    |-> hrdata[15:0] == $past(hwdata[15:0], 2))
    else $error("read back differs from write");
  chk_pb6_addr: assert property (fld[4] == 2'h2 && !single_chip_mode
    |=> !pins.pb_oe_n[6] && pins.pb_out[6] == $past(address_bus[18]))
    else $error("pin 6 address 18 not driven");
  chk_pb5_irq: assert property (fld[3] == 2'h1
    |=> pins.pb_oe_n[5] && interrupt_lines[3] == $past(portb_pin_in[5]))
    else $error("pin 5 interrupt not routed");
  chk_pb5_poe: assert property (fld[3] == 2'h2
    |=> pins.pb_oe_n[5] && output_disable_requests[3] == $past(portb_pin_in[5]))
    else $error("pin 5 disable request not routed");
  chk_pb4_cas: assert property (fld[2] == 2'h3 && !single_chip_mode
    |=> !pins.pb_oe_n[4] && pins.pb_out[4] == $past(strobes.upper_column_strobe))
    else $error("pin 4 upper column strobe not driven");
  chk_pb0_single: assert property (st_ff.pb_sel[0] && single_chip_mode
    |=> pins.pb_oe_n[0] == !$past(portb_gpio_dir[0]))
    else $error("pin 0 not general I/O in single-chip mode");
  chk_pcdir_write: assert property (wr_dp && st_ff.idx == pbcpf_pkg::OFS_PC_DIR
    |=> st_ff.pc_dir == $past(hwdata[15:0]))
    else $error("port C direction write lost");
  chk_pc_rom: assert property (!st_ff.pc_sel[0] && rom_invalid_mode
    |=> !pins.pc_oe_n[0] && pins.pc_out[0] == $past(address_bus[0]))
    else $error("port C pin 0 address missing");

  cov_strobe: cover property (fld[0] == 2'h3 ##1 !pins.pb_oe_n[2]);
  cov_readback: cover property (wr_dp ##2 st_ff.bus == pbcpf_pkg::BUS_DATA && !st_ff.wr);
  cov_pb_irq: cover property (fld[4] == 2'h1 ##1 !interrupt_lines[4]);
  cov_pc_addr: cover property (st_ff.pc_sel != 16'h0000 && !single_chip_mode);
  cov_read: cover property (st_ff.bus == pbcpf_pkg::BUS_DATA && !st_ff.wr);

endmodule

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the port B/C pin function block
// Assumes: Single AHB-Lite slave, hready fed back from hreadyout
// Notes: Expected values queue up; one watcher process drains and compares them
`timescale 1ns/1ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic single_chip_mode = 1'b0;
  logic rom_invalid_mode = 1'b0;
  logic [18:0] address_bus = 19'h00000;
  pbcpf_pkg::pbcpf_strobe_t strobes = 5'h00;
  logic [6:0] portb_gpio_out = 7'h00;
  logic [6:0] portb_gpio_dir = 7'h00;
  logic [6:0] portb_pin_in = 7'h00;
  logic [15:0] portc_gpio_out = 16'h0000;
  pbcpf_pkg::pbcpf_pin_t pins;
  logic [4:0] interrupt_lines;
  logic [3:0] output_disable_requests;
  logic [63:0] exp_q[$];
  logic [63:0] act_q[$];
  logic [63:0] msk_q[$];
  logic [63:0] qe, qa, qm;
  logic [31:0] seed = 32'h0000000D;
  event res_ev;
  int n_fail = 0;
  int checks_done = 0;

  pbcpf_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .single_chip_mode(single_chip_mode), .rom_invalid_mode(rom_invalid_mode),
    .address_bus(address_bus), .strobes(strobes), .portb_gpio_out(portb_gpio_out),
    .portb_gpio_dir(portb_gpio_dir), .portc_gpio_out(portc_gpio_out),
    .portb_pin_in(portb_pin_in), .pins(pins), .interrupt_lines(interrupt_lines),
    .output_disable_requests(output_disable_requests)
  );

  always #5 hclk = ~hclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic note(input logic [63:0] e, input logic [63:0] a, input logic [63:0] m);
    exp_q.push_back(e);
    act_q.push_back(a);
    msk_q.push_back(m);
    ->res_ev;
  endtask

  always @(res_ev)
  begin
    while (exp_q.size() > 0)
    begin
      qe = exp_q.pop_front();
      qa = act_q.pop_front();
      qm = msk_q.pop_front();
      checks_done++;
      if ((qa & qm) !== (qe & qm))
      begin
        n_fail++;
        $display("[FAIL] %0t: got %h expected %h mask %h", $time, qa, qe, qm);
      end
    end
  end

  // One single transfer, begun right after a rising edge; answers taken at rising edges
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                     output logic [31:0] rd);
    logic rdy;
    hsel <= 1'b1;
    htrans <= pbcpf_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    rdy = 1'b0;
    while (rdy !== 1'b1)
    begin
      @(posedge hclk);
      rdy = hreadyout;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    rdy = 1'b0;
    rd = 32'h00000000;
    while (rdy !== 1'b1)
    begin
      @(posedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      note(64'h0, {63'h0, hresp}, 64'h1);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] rd;
    ahb(1'b0, a, 16'h0000, rd);
    note({48'h0, e}, {32'h0, rd}, 64'hFFFFFFFF);
  endtask

  task automatic pins_chk(input logic [15:0] pb, input logic [15:0] dr,
                          input logic [15:0] pc, input int m);
    pbcpf_pkg::pbcpf_pin_t e;
    pbcpf_pkg::pbcpf_pin_t mk;
    logic [4:0] ei;
    logic [3:0] eo;
    logic sc, ri, a;
    int n, c;
    sc = (m == 1);
    ri = (m == 2);
    mk = '1;
    ei = 5'h1F;
    eo = 4'hF;
    for (n = 0; n < 16; n++)
    begin
      a = ri | (pc[n] & ~sc);
      e.pc_out[n] = a ? address_bus[n] : portc_gpio_out[n];
      e.pc_oe_n[n] = ~(a | dr[n]);
    end
    for (n = 0; n < 7; n++)
    begin
      e.pb_out[n] = portb_gpio_out[n];
      e.pb_oe_n[n] = ~portb_gpio_dir[n];
      c = (n > 1) ? int'(pb[2*n +: 2]) : 0;
      a = (n < 2) ? (ri | (pb[2*n] & ~sc)) : 1'b0;
      if (a)
      begin
        e.pb_out[n] = address_bus[16+n];
        e.pb_oe_n[n] = 1'b0;
      end
      else if (c == 1)
      begin
        ei[n-2] = portb_pin_in[n];
        e.pb_oe_n[n] = 1'b1;
      end
      else if (c == 2 && n < 6)
      begin
        eo[n-2] = portb_pin_in[n];
        e.pb_oe_n[n] = 1'b1;
      end
      else if (c == 2 && !sc)
      begin
        e.pb_out[n] = address_bus[18];
        e.pb_oe_n[n] = 1'b0;
      end
      else if (c == 3 && (!sc || n == 5))
      begin
        e.pb_out[n] = strobes[n-2];
        e.pb_oe_n[n] = 1'b0;
      end
    end
    mk.pb_out = ~e.pb_oe_n;
    mk.pc_out = ~e.pc_oe_n;
    note({18'h0, e}, {18'h0, pins}, {18'h0, mk});
    note({55'h0, ei, eo}, {55'h0, interrupt_lines, output_disable_requests}, '1);
  endtask

  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    logic [31:0] rd;
    logic [15:0] pb, dr, pc;
    int it, m;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(pbcpf_pkg::OFS_PB_SEL, 16'h0000);
    rd_chk(pbcpf_pkg::OFS_PC_DIR, 16'h0000);
    rd_chk(pbcpf_pkg::OFS_PC_SEL, 16'h0000);
    @(negedge hclk);
    pins_chk(16'h0000, 16'h0000, 16'h0000, 0);
    for (it = 0; it < 36; it++)
    begin
      m = it % 3;
      pb = 16'(xs()) & pbcpf_pkg::PB_SEL_MASK;
      dr = 16'(xs());
      pc = 16'(xs());
      @(posedge hclk);
      ahb(1'b1, pbcpf_pkg::OFS_PB_SEL, pb, rd);
      ahb(1'b1, pbcpf_pkg::OFS_PC_DIR, dr, rd);
      ahb(1'b1, pbcpf_pkg::OFS_PC_SEL, pc, rd);
      rd_chk(pbcpf_pkg::OFS_PB_SEL, pb);
      rd_chk(pbcpf_pkg::OFS_PC_DIR, dr);
      rd_chk(pbcpf_pkg::OFS_PC_SEL, pc);
      @(posedge hclk);
      single_chip_mode <= (m == 1);
      rom_invalid_mode <= (m == 2);
      address_bus <= 19'(xs());
      strobes <= 5'(xs());
      portb_gpio_out <= 7'(xs());
      portb_gpio_dir <= 7'(xs());
      portb_pin_in <= 7'(xs());
      portc_gpio_out <= 16'(xs());
      @(posedge hclk);
      @(negedge hclk);
      pins_chk(pb, dr, pc, m);
    end
    @(posedge hclk);
    ahb(1'b1, 8'h0C, 16'hA5C3, rd);
    rd_chk(8'h0C, 16'h0000);
    rd_chk(pbcpf_pkg::OFS_PC_DIR, dr);
    rd_chk(pbcpf_pkg::OFS_PC_SEL, pc);
    ahb(1'b1, pbcpf_pkg::OFS_PC_DIR, 16'h5AC3, rd);
    rd_chk(pbcpf_pkg::OFS_PC_DIR, 16'h5AC3);
    @(posedge hclk);
    hresetn <= 1'b0;
    single_chip_mode <= 1'b0;
    rom_invalid_mode <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(pbcpf_pkg::OFS_PC_DIR, 16'h0000);
    rd_chk(pbcpf_pkg::OFS_PC_SEL, 16'h0000);
    rd_chk(pbcpf_pkg::OFS_PB_SEL, 16'h0000);
    @(negedge hclk);
    pins_chk(16'h0000, 16'h0000, 16'h0000, 0);
    @(negedge hclk);
    stop_test();
  end
endmodule
